// file: src/acr_ctrl.sv
// converter control/status register with avalon-mm slave and interrupt
// assumes the analog core reports conversion end with a one-cycle pulse
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module acr_ctrl
	import acr_pkg::*;
#(
	parameter int CONV_TIMEOUT = CONV_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// avalon-mm slave
	input wire acr_req_s av_req_i,
	output logic [31:0] av_readdata_o,
	output logic av_waitrequest_o,
	// converter core
	input wire logic conv_done_i,
	input wire logic [RES_W-1:0] conv_result_i,
	output acr_conv_s conv_o,
	// interrupt
	output logic irq_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_RUN} acr_state_e;
	acr_state_e state_q;
	logic [7:0] ctrl_q;
	logic chsel_hi_q;
	logic [RES_W-1:0] result_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic wr_ctrl;
	logic start_new;
	logic start_rise;
	logic start_fall;
	logic [15:0] res_pair;
	logic [7:0] ctrl_rd;
	logic rd_stat;
	logic [1:0] ev;
	logic access;
	logic [1:0] stat_clr;

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, then answer
	assign access = av_req_i.read | av_req_i.write;
	assign av_waitrequest_o = access & ~ack_q;
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			ack_q <= 1'b0;
		else
			ack_q <= access & ~ack_q;
	end
	assign wr_ctrl = av_req_i.write & ack_q & (av_req_i.address == OFS_CTRL0);
	assign rd_stat = av_req_i.read & ack_q &
		(av_req_i.address == OFS_IRQ_STAT);
	assign start_new = wr_ctrl ? av_req_i.writedata[BIT_START]
		: ctrl_q[BIT_START];
	assign start_rise = start_new & ~ctrl_q[BIT_START];
	assign start_fall = ~start_new & ctrl_q[BIT_START];

	////////////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ctrl_q <= CTRL0_RESET;
		end else begin
			if (wr_ctrl)
				ctrl_q <= (av_req_i.writedata[7:0] & CTRL0_WMASK) |
					(ctrl_q & ~CTRL0_WMASK);
			if (start_rise)
				ctrl_q[BIT_BUSY] <= 1'b1;
			else if (state_q == ST_RUN && conv_done_i)
				ctrl_q[BIT_BUSY] <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			chsel_hi_q <= 1'b0;
		else if (av_req_i.write & ack_q & (av_req_i.address == OFS_CHSEL_HI))
			chsel_hi_q <= av_req_i.writedata[0];
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			state_q <= ST_IDLE;
		end else if (start_rise) begin
			state_q <= ST_RESET;
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_RESET: if (start_fall)
					state_q <= ST_RUN;
				ST_RUN: if (conv_done_i)
					state_q <= ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			result_q <= '0;
		else if (state_q == ST_RUN && conv_done_i)
			result_q <= conv_result_i;
	end
	assign conv_o.conv_rst = state_q == ST_RESET;
	assign conv_o.conv_start = state_q == ST_RESET && start_fall;
	assign conv_o.power_down = ctrl_q[BIT_PDOWN];
	assign conv_o.channel = {chsel_hi_q, ctrl_q[1:0]};

	////////////////////////////////////////////////////////////////////////
	// interrupt: bit0 conversion done, bit1 conversion started
	assign ev = {start_fall & (state_q == ST_RESET),
		state_q == ST_RUN && conv_done_i};
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~stat_clr) | ev;
	end
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			irq_mask_q <= '0;
		else if (av_req_i.write & ack_q & (av_req_i.address == OFS_IRQ_MASK))
			irq_mask_q <= av_req_i.writedata[1:0];
	end
	// read clears only the bits it returned; set wins
	assign stat_clr = rd_stat ? rdata_q[1:0] : 2'h0;
	assign irq_o = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////
	// read path
	// result alignment
	assign res_pair = ctrl_q[BIT_ALIGN] ? {{NIBBLE{1'b0}}, result_q}
		: {result_q, {NIBBLE{1'b0}}};
	always_comb begin
		ctrl_rd = ctrl_q & CTRL0_WMASK;
		ctrl_rd[BIT_BUSY] = ctrl_q[BIT_BUSY];
	end
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rdata_q <= '0;
		end else if (av_req_i.read & ~ack_q) begin
			unique case (av_req_i.address)
				OFS_CTRL0: rdata_q <= {24'h0, ctrl_rd};
				OFS_RES_LO: rdata_q <= {24'h0, res_pair[7:0]};
				OFS_RES_HI: rdata_q <= {24'h0, res_pair[15:8]};
				OFS_CHSEL_HI: rdata_q <= {31'h0, chsel_hi_q};
				OFS_IRQ_STAT: rdata_q <= {30'h0, irq_stat_q};
				OFS_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
				default: rdata_q <= UNMAPPED_DATA;
			endcase
		end
	end
	assign av_readdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence start_pulse_s;
		start_rise ##1 (state_q == ST_RESET && ctrl_q[BIT_BUSY]);
	endsequence
	sequence conv_end_s;
		state_q == ST_RUN && conv_done_i && !start_rise;
	endsequence
	busy_on_start_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) start_rise |-> start_pulse_s)
		else $error("busy not set on start");
	conv_rst_hold_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) start_rise |=> conv_o.conv_rst)
		else $error("converter not held in reset");
	conv_begin_fall_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) (state_q == ST_RESET && start_fall)
		|=> state_q == ST_RUN)
		else $error("conversion did not begin on fall");
	start_pulse_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) conv_o.conv_start
		|=> !conv_o.conv_start && !conv_o.conv_rst)
		else $error("start pulse longer than one cycle");
	busy_readonly_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) !start_rise && !(state_q == ST_RUN &&
		conv_done_i) |=> $stable(ctrl_q[BIT_BUSY]))
		else $error("busy changed outside sequencer");
	busy_running_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) (state_q != ST_IDLE) |-> ctrl_q[BIT_BUSY])
		else $error("busy low while running");
	busy_clear_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) conv_end_s |=> !ctrl_q[BIT_BUSY] &&
		state_q == ST_IDLE)
		else $error("busy not cleared at end");
	power_down_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) wr_ctrl |=>
		conv_o.power_down == $past(av_req_i.writedata[BIT_PDOWN]))
		else $error("power-down bit not applied");
	align_left_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) !ctrl_q[BIT_ALIGN] |->
		res_pair[NIBBLE-1:0] == 4'h0)
		else $error("left alignment low nibble not zero");
	channel_map_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) wr_ctrl |=>
		conv_o.channel[1:0] == $past(av_req_i.writedata[1:0]))
		else $error("channel bits not applied");
	one_wait_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) av_waitrequest_o |=> !av_waitrequest_o)
		else $error("more than one wait state");
	stat_set_wins_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) ev[0] |=> irq_stat_q[0])
		else $error("done event lost from status");
	stat_read_clear_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) rd_stat && rdata_q[0] && !ev[0]
		|=> !irq_stat_q[0])
		else $error("status not cleared by read");
	reset_value_a: assert property (@(posedge sys_clk_i)
		$rose(resetn_i) |-> ctrl_q == CTRL0_RESET)
		else $error("bad reset value");
	align_right_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) ctrl_q[BIT_ALIGN] |-> res_pair[15:12] == 4'h0)
		else $error("right alignment high nibble not zero");
	unused_zero_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) ctrl_rd[3:2] == 2'h0)
		else $error("unimplemented bits not zero");
endmodule

// file: src/acr_pkg.sv
// constants and carriers for the converter control/status register block
// assumes a single system clock and an Avalon-MM master on the register bus
package acr_pkg;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_RES_LO = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_RES_HI = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_CHSEL_HI = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h5;
	localparam int BIT_START = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_PDOWN = 5;
	localparam int BIT_ALIGN = 4;
	localparam logic [7:0] CTRL0_RESET = 8'h60;
	localparam logic [7:0] CTRL0_WMASK = 8'hb3;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	localparam int RES_W = 12;
	localparam int NIBBLE = 4;
	localparam int CONV_CYCLES = 16;
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} acr_req_s;
	typedef struct packed {
		logic conv_rst;
		logic conv_start;
		logic power_down;
		logic [2:0] channel;
	} acr_conv_s;
endpackage

// file: bench/tb.sv
// bench for the converter control/status register block
// drives the avalon-mm request, converter done pulse and reset directly
`timescale 1ns/1ns
module tb;
	import acr_pkg::*;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	acr_req_s av_req_i = '0;
	logic [31:0] av_readdata_o;
	logic av_waitrequest_o;
	logic conv_done_i = 1'b0;
	logic [RES_W-1:0] conv_result_i = '0;
	acr_conv_s conv_o;
	logic irq_o;
	int failures = 0;
	int check_count = 0;
	int starts = 0;
	logic [31:0] q;
	// rows: control write value, expected control read value
	logic [15:0] rows [7] = '{16'h0040, 16'h3f73, 16'h0141, 16'h0242,
		16'h0343, 16'h5050, 16'h0c40};
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
$display("BAD %s exp %h got %h", n, e, g); end end

	always #4 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		if (conv_o.conv_start === 1'b1)
			starts++;
	end

	acr_ctrl u_dut (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.av_req_i(av_req_i),
		.av_readdata_o(av_readdata_o),
		.av_waitrequest_o(av_waitrequest_o),
		.conv_done_i(conv_done_i),
		.conv_result_i(conv_result_i),
		.conv_o(conv_o),
		.irq_o(irq_o)
	);

	////////////////////////////////////////////////////////////////////////
	task final_report;
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one avalon access, held until waitrequest is sampled low at an edge
	task automatic bus(input logic [2:0] a, input logic rd, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		av_req_i <= '{address: a, read: rd, write: !rd, writedata: {24'h0, d}};
		@(posedge sys_clk_i);
		while (av_waitrequest_o !== 1'b0 && n < 40) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 40) begin
			failures++;
			final_report();
		end
		q = av_readdata_o;
		av_req_i <= '0;
	endtask

	task automatic rdchk(input string n, input logic [2:0] a,
		input logic [31:0] e);
		bus(a, 1'b1, 8'h00);
		`CHK(n, e, q)
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		foreach (rows[i]) begin
			bus(OFS_CTRL0, 1'b0, rows[i][15:8]);
			rdchk("ctrl", OFS_CTRL0, {24'h0, rows[i][7:0]});
			@(negedge sys_clk_i);
			`CHK("pdown", rows[i][13], conv_o.power_down)
			`CHK("chan", {1'b0, rows[i][9:8]}, conv_o.channel)
		end
		bus(OFS_IRQ_MASK, 1'b0, 8'h01);
		bus(OFS_CTRL0, 1'b0, 8'h80);
		repeat (2) @(negedge sys_clk_i);
		`CHK("conv_rst", 1'b1, conv_o.conv_rst)
		rdchk("busy_set", OFS_CTRL0, 32'hc0);
		bus(OFS_CTRL0, 1'b0, 8'h00);
		repeat (2) @(negedge sys_clk_i);
		`CHK("starts", 1, starts)
		`CHK("rst_off", 1'b0, conv_o.conv_rst)
		`CHK("irq_masked", 1'b0, irq_o)
		rdchk("running", OFS_CTRL0, 32'h40);
		@(posedge sys_clk_i);
		conv_done_i <= 1'b1;
		conv_result_i <= 12'habc;
		@(posedge sys_clk_i);
		conv_done_i <= 1'b0;
		repeat (3) @(negedge sys_clk_i);
		`CHK("irq_set", 1'b1, irq_o)
		rdchk("done", OFS_CTRL0, 32'h00);
		bus(OFS_CTRL0, 1'b0, 8'h40);
		rdchk("busy_ro", OFS_CTRL0, 32'h00);
		rdchk("status", OFS_IRQ_STAT, 32'h03);
		@(negedge sys_clk_i);
		`CHK("irq_clr", 1'b0, irq_o)
		rdchk("res_hi_l", OFS_RES_HI, 32'hab);
		rdchk("res_lo_l", OFS_RES_LO, 32'hc0);
		bus(OFS_CTRL0, 1'b0, 8'h10);
		rdchk("res_hi_r", OFS_RES_HI, 32'h0a);
		rdchk("res_lo_r", OFS_RES_LO, 32'hbc);
		bus(OFS_RES_LO, 1'b0, 8'hff);
		rdchk("res_ro", OFS_RES_LO, 32'hbc);
		bus(OFS_CHSEL_HI, 1'b0, 8'h01);
		bus(OFS_CTRL0, 1'b0, 8'h03);
		@(negedge sys_clk_i);
		`CHK("chan_hi", 3'b111, conv_o.channel)
		rdchk("unmapped", 3'h7, UNMAPPED_DATA);
		@(posedge sys_clk_i);
		resetn_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rdchk("reset_val", OFS_CTRL0, 32'h60);
		@(negedge sys_clk_i);
		`CHK("pd_reset", 1'b1, conv_o.power_down)
		`CHK("irq_reset", 1'b0, irq_o)
		final_report();
	end
endmodule
